/* shared/vsc_defs.vh */
// Constants for the VPW frame, symbol and check-byte codec.
// Assumes a single interface clock; all symbol times are whole microseconds.
`ifndef VSC_DEFS_VH
`define VSC_DEFS_VH
// Interface clock rate in MHz
`define VSC_CLK_MHZ 25
// Nominal symbol times in microseconds
`define VSC_SHORT_US 64
`define VSC_LONG_US 128
`define VSC_SOF_US 200
`define VSC_BRK_US 240
`define VSC_EOF_US 280
`define VSC_IFS_US 20
`define VSC_IDLE_US 300
// Receive window points a, b, c in microseconds
`define VSC_WIN_A_US 32
`define VSC_WIN_B_US 96
`define VSC_WIN_C_US 164
// Late-write limit after a resync edge, in clock cycles
`define VSC_SYNC_CYC 104
// Tolerated echo mismatch before arbitration is lost, in cycles
`define VSC_ARB_CYC 8
// Check byte generator
`define VSC_CRC_POLY 8'h1d
`define VSC_CRC_INIT 8'hff
`define VSC_CRC_GOOD 8'hc4
// Register byte offsets
`define VSC_ADDR_DATA 8'h00
`define VSC_ADDR_CTRL 8'h04
`define VSC_ADDR_STAT 8'h08
// Status field positions
`define VSC_ST_CRC 0
`define VSC_ST_EOF 1
`define VSC_ST_INV 2
`define VSC_ST_RXF 3
`define VSC_ST_TXE 4
`define VSC_ST_TERR 5
`define VSC_ST_ARB 6
`define VSC_ST_IDLE 7
// Control and data-write field positions
`define VSC_CT_4X 0
`define VSC_DW_LAST 8
// Reset values
`define VSC_FLAGS_RST 7'h00
`define VSC_CTRL_RST 1'b0
`endif

/* src/vsc_codec.v */
// VPW bit and symbol codec with check byte, resync and an APB register slave.
// Assumes an off-chip transceiver: link_tx high drives the bus active, link_rx high means active.
//
// Function
// - Check polynomial x8+x4+x3+x2+1, preset ones
// - Append inverted remainder, MSB first
// - Receive remainder not C4 sets CRC error
// - 200us passive end-of-data sets no flag
// - 280us passive end-of-frame sets flag
// - Wait 300us passive before start-of-frame
// - Resync to rising edge during separation
// - Write within 104 cycles transmits, else waits
// - Never send break; break aborts transmit
// - Break in frame: invalid flag, drop frame
// - Break in frame clears fourfold enable
// - Passive beyond 300us is idle bus
// - Zero: 64us passive or 128us active
// - One: 128us passive or 64us active
// - Levels alternate; bytes begin passive
// - Start symbol 200us active, not checked
// - Active 240us or longer is break
// - Windows abut with one-cycle resolution
// - Short passive period is invalid bit
// - Normalization bit coded like data bits
// - MSB first; one data byte minimum
// - Passive ending between c and d: end-of-data
// - Zero dominates; recessive loser stops sending
//
// Our own choices: the register offsets and register access over APB.
`timescale 1ns/100ps
`include "vsc_defs.vh"

module vsc_codec #(
	parameter [15:0] SOF_CYC = `VSC_SOF_US * `VSC_CLK_MHZ,
	parameter [15:0] BRK_CYC = `VSC_BRK_US * `VSC_CLK_MHZ,
	parameter [15:0] EOF_CYC = `VSC_EOF_US * `VSC_CLK_MHZ,
	parameter [15:0] IDLE_CYC = `VSC_IDLE_US * `VSC_CLK_MHZ,
	parameter [15:0] WIN_C_CYC = `VSC_WIN_C_US * `VSC_CLK_MHZ
) (
	// Clock and reset
	input wire pclk,
	input wire presetn,
	// APB slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	// Transceiver pins
	input wire link_rx,
	output reg link_tx
);

	// Short counts, cycle-exact at the clock rate
	localparam [15:0] SHORT_CYC = `VSC_SHORT_US * `VSC_CLK_MHZ;
	localparam [15:0] LONG_CYC = `VSC_LONG_US * `VSC_CLK_MHZ;
	localparam [15:0] WIN_A_CYC = `VSC_WIN_A_US * `VSC_CLK_MHZ;
	localparam [15:0] WIN_B_CYC = `VSC_WIN_B_US * `VSC_CLK_MHZ;
	localparam [15:0] SYNC_CYC = `VSC_SYNC_CYC;
	localparam [3:0] ARB_CYC = `VSC_ARB_CYC;
	// Transmit states
	localparam [1:0] T_IDLE = 2'b00;
	localparam [1:0] T_SOF = 2'b01;
	localparam [1:0] T_BIT = 2'b10;
	// Register select codes
	localparam [1:0] SEL_NONE = 2'b00;
	localparam [1:0] SEL_DATA = 2'b01;
	localparam [1:0] SEL_CTRL = 2'b10;
	localparam [1:0] SEL_STAT = 2'b11;

	// One serial step of the check generator
	function [7:0] crc_step;
		input [7:0] rem;
		input b;
		begin
			crc_step = {rem[6:0], 1'b0} ^ ((rem[7] ^ b) ? `VSC_CRC_POLY : 8'h00);
		end
	endfunction

	// Window scaled down by four in fourfold receive mode
	function [15:0] thr;
		input [15:0] x;
		input q;
		begin
			thr = q ? {2'b00, x[15:2]} : x;
		end
	endfunction

	// Register decode, shared by reads and writes
	function [1:0] reg_sel;
		input [7:0] a;
		begin
			if (a == `VSC_ADDR_DATA)
				reg_sel = SEL_DATA;
			else if (a == `VSC_ADDR_CTRL)
				reg_sel = SEL_CTRL;
			else if (a == `VSC_ADDR_STAT)
				reg_sel = SEL_STAT;
			else
				reg_sel = SEL_NONE;
		end
	endfunction

	// Pin synchroniser and edge history
	reg rx_m_r; // First stage, read only by second
	reg rx_s_r; // Synchronised bus level
	reg rx_d_r; // Level of the period now running
	reg [15:0] cnt_r; // Cycles since the last bus edge
	// Receive frame state
	reg in_frame_r;
	reg eod_r; // End-of-data seen, frame end pending
	reg eof_r; // Frame end seen, separation running
	reg idle_r;
	reg [7:0] rcrc_r;
	reg [2:0] rbit_r;
	reg [7:0] rsh_r;
	reg [7:0] rbyte_r;
	// Transmit state
	reg [1:0] ts_r;
	reg [15:0] tcnt_r;
	reg [15:0] tlen_r;
	reg [7:0] tsh_r;
	reg [3:0] tbit_r;
	reg [7:0] tcrc_r;
	reg tcrc_ph_r; // Check byte is on the wire
	reg tlast_r; // Byte in shifter is the last data byte
	reg [7:0] tbuf_r;
	reg tbuf_last_r;
	reg tfull_r;
	reg [3:0] amis_r;
	reg sync_r;
	reg [15:0] scnt_r;
	reg ev_arb_r;
	reg ev_terr_r;
	// Software-visible state
	reg [6:0] flags_r; // Sticky flags, status bits 0..3 and 5..6
	reg fourx_r; // fourfold_rx_enable

	// Edges and the period that just ended
	wire rise = rx_s_r & ~rx_d_r;
	wire fall = ~rx_s_r & rx_d_r;
	wire steady = rx_s_r == rx_d_r;
	// Completing APB access, the one edge where writes act
	wire apb_done = psel & penable & pready;
	wire wr_data = apb_done & pwrite & (reg_sel(paddr) == SEL_DATA);
	wire wr_ctrl = apb_done & pwrite & (reg_sel(paddr) == SEL_CTRL);
	wire wr_stat = apb_done & pwrite & (reg_sel(paddr) == SEL_STAT);
	wire rd_data = apb_done & ~pwrite & (reg_sel(paddr) == SEL_DATA);
	wire tx_busy = ts_r != T_IDLE;

	// Receive classification of each period
	reg ev_sof, ev_bit, ev_val, ev_inv, ev_brk, ev_eod, ev_eof, ev_idle, ev_crc, ev_byte;
	always @*
	begin
		ev_sof = 1'b0;
		ev_bit = 1'b0;
		ev_val = 1'b0;
		ev_inv = 1'b0;
		ev_brk = 1'b0;
		ev_eod = 1'b0;
		ev_eof = 1'b0;
		ev_idle = 1'b0;
		// Active period ended
		if (fall)
		begin
			if (cnt_r < thr(WIN_A_CYC, fourx_r))
				ev_inv = in_frame_r;
			else if (cnt_r < thr(WIN_B_CYC, fourx_r))
			begin
				ev_bit = in_frame_r;
				ev_val = 1'b1;
			end
			// Active zero ends at point c, where a start symbol begins
			else if (cnt_r < thr(WIN_C_CYC, fourx_r))
				ev_bit = in_frame_r;
			else if (cnt_r < thr(BRK_CYC, fourx_r))
				ev_sof = 1'b1;
		end
		// Passive period ended inside a frame
		if (rise && in_frame_r)
		begin
			if (cnt_r < thr(WIN_A_CYC, fourx_r))
				ev_inv = 1'b1;
			else if (cnt_r < thr(WIN_B_CYC, fourx_r))
				ev_bit = 1'b1;
			else
			begin
				ev_bit = 1'b1;
				ev_val = 1'b1;
			end
		end
		// Thresholds crossed while the level holds; each is hit once
		if (steady && rx_s_r && cnt_r == thr(BRK_CYC, fourx_r))
			ev_brk = 1'b1;
		if (steady && !rx_s_r && in_frame_r && cnt_r == thr(WIN_C_CYC, fourx_r))
			ev_eod = 1'b1;
		if (steady && !rx_s_r && eod_r && cnt_r == thr(EOF_CYC, fourx_r))
			ev_eof = 1'b1;
		if (steady && !rx_s_r && cnt_r == thr(IDLE_CYC, fourx_r))
			ev_idle = 1'b1;
		// Frame ends on a byte boundary with the fixed remainder
		ev_crc = ev_eod & (rcrc_r != `VSC_CRC_GOOD);
		ev_byte = ev_bit & (rbit_r == 3'd7);
		if (ev_eod && rbit_r != 3'd0)
			ev_inv = 1'b1;
	end

	// Synchroniser, period counter and receive framing
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rx_m_r <= 1'b0;
			rx_s_r <= 1'b0;
			rx_d_r <= 1'b0;
			cnt_r <= 16'h0000;
			in_frame_r <= 1'b0;
			eod_r <= 1'b0;
			eof_r <= 1'b0;
			idle_r <= 1'b0;
			rcrc_r <= `VSC_CRC_INIT;
			rbit_r <= 3'd0;
			rsh_r <= 8'h00;
			rbyte_r <= 8'h00;
		end
		else
		begin
			rx_m_r <= link_rx;
			rx_s_r <= rx_m_r;
			rx_d_r <= rx_s_r;
			// Restart on any edge, saturate on long idle
			if (rise || fall)
				cnt_r <= 16'h0000;
			else if (cnt_r != 16'hffff)
				cnt_r <= cnt_r + 16'h0001;
			// Start symbol opens a frame and presets the remainder
			if (ev_sof)
			begin
				in_frame_r <= 1'b1;
				rcrc_r <= `VSC_CRC_INIT;
				rbit_r <= 3'd0;
				eod_r <= 1'b0;
			end
			else if (ev_inv || ev_brk)
				in_frame_r <= 1'b0;
			else if (ev_eod)
			begin
				in_frame_r <= 1'b0;
				eod_r <= 1'b1;
			end
			else if (ev_bit)
			begin
				// Normalization bits shift in like data; no response decode here
				rsh_r <= {rsh_r[6:0], ev_val};
				rcrc_r <= crc_step(rcrc_r, ev_val);
				rbit_r <= rbit_r + 3'd1;
				if (ev_byte)
					rbyte_r <= {rsh_r[6:0], ev_val};
			end
			// A response edge or the frame end retires end-of-data
			if (ev_eof || rise)
				eod_r <= 1'b0;
			// Separation window opens at frame end
			if (ev_eof)
				eof_r <= 1'b1;
			else if (ev_idle || rise)
				eof_r <= 1'b0;
			if (ev_idle)
				idle_r <= 1'b1;
			else if (rise)
				idle_r <= 1'b0;
		end
	end

	// Next transmitted bit and its symbol length
	reg t_end, t_byte_end, t_fin, t_und, t_crcnow, t_b, t_lvl;
	reg [7:0] t_src;
	reg [15:0] t_len;
	always @*
	begin
		t_end = tcnt_r + 16'h0001 >= tlen_r;
		t_byte_end = tbit_r == 4'd8;
		t_src = t_byte_end ? (tlast_r ? ~tcrc_r : tbuf_r) : tsh_r;
		t_fin = t_byte_end & (tcrc_ph_r | (~tlast_r & ~tfull_r));
		t_und = t_byte_end & ~tcrc_ph_r & ~tlast_r & ~tfull_r;
		t_crcnow = tcrc_ph_r | (t_byte_end & tlast_r);
		t_b = t_src[7];
		t_lvl = ~link_tx;
		if (t_lvl)
			t_len = t_b ? SHORT_CYC : LONG_CYC;
		else
			t_len = t_b ? LONG_CYC : SHORT_CYC;
	end

	// Transmit start, resync, bit timing and arbitration
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ts_r <= T_IDLE;
			link_tx <= 1'b0;
			tcnt_r <= 16'h0000;
			tlen_r <= SOF_CYC;
			tsh_r <= 8'h00;
			tbit_r <= 4'd0;
			tcrc_r <= `VSC_CRC_INIT;
			tcrc_ph_r <= 1'b0;
			tlast_r <= 1'b0;
			tbuf_r <= 8'h00;
			tbuf_last_r <= 1'b0;
			tfull_r <= 1'b0;
			amis_r <= 4'd0;
			sync_r <= 1'b0;
			scnt_r <= 16'h0000;
			ev_arb_r <= 1'b0;
			ev_terr_r <= 1'b0;
		end
		else
		begin
			ev_arb_r <= 1'b0;
			ev_terr_r <= 1'b0;
			// Resync window opened by a rising edge during separation
			if (rise && eof_r && !tx_busy)
			begin
				sync_r <= 1'b1;
				scnt_r <= 16'h0000;
			end
			else if (sync_r)
			begin
				scnt_r <= scnt_r + 16'h0001;
				if (scnt_r >= SYNC_CYC || tx_busy)
					sync_r <= 1'b0;
			end
			case (ts_r)
				T_IDLE:
				begin
					amis_r <= 4'd0;
					// Idle bus, or a late start aligned to another node's edge
					if (tfull_r && ((idle_r && !rx_s_r) || (rise && eof_r) || (sync_r && scnt_r <= SYNC_CYC)))
					begin
						ts_r <= T_SOF;
						link_tx <= 1'b1;
						tlen_r <= SOF_CYC;
						tcnt_r <= (sync_r && !rise) ? scnt_r : 16'h0000;
						tsh_r <= tbuf_r;
						tlast_r <= tbuf_last_r;
						tfull_r <= 1'b0;
						tbit_r <= 4'd0;
						tcrc_r <= `VSC_CRC_INIT;
						tcrc_ph_r <= 1'b0;
					end
				end
				T_SOF, T_BIT:
				begin
					tcnt_r <= tcnt_r + 16'h0001;
					// Echo disagreeing beyond the loop delay means we lost
					if (rx_s_r != link_tx)
						amis_r <= amis_r + 4'd1;
					else
						amis_r <= 4'd0;
					if (ev_brk)
					begin
						ts_r <= T_IDLE;
						link_tx <= 1'b0;
						ev_terr_r <= 1'b1;
					end
					else if (amis_r >= ARB_CYC)
					begin
						ts_r <= T_IDLE;
						link_tx <= 1'b0;
						ev_arb_r <= 1'b1;
					end
					else if (t_end)
					begin
						if (t_fin)
						begin
							// Last bit ends active, so the end-of-data starts here
							ts_r <= T_IDLE;
							link_tx <= 1'b0;
							ev_terr_r <= t_und;
						end
						else
						begin
							ts_r <= T_BIT;
							link_tx <= t_lvl;
							tcnt_r <= 16'h0000;
							tlen_r <= t_len;
							tsh_r <= {t_src[6:0], 1'b0};
							tbit_r <= t_byte_end ? 4'd1 : tbit_r + 4'd1;
							tcrc_ph_r <= t_crcnow;
							if (!t_crcnow)
								tcrc_r <= crc_step(tcrc_r, t_b);
							if (t_byte_end && !tlast_r)
							begin
								tlast_r <= tbuf_last_r;
								tfull_r <= 1'b0;
							end
						end
					end
				end
				default:
				begin
					ts_r <= T_IDLE;
					link_tx <= 1'b0;
				end
			endcase
			// Software write wins over an internal load
			if (wr_data)
			begin
				tbuf_r <= pwdata[7:0];
				tbuf_last_r <= pwdata[`VSC_DW_LAST];
				tfull_r <= 1'b1;
			end
		end
	end

	// Sticky flags: hardware set wins over a write-one clear
	wire [6:0] flag_set = {ev_arb_r, ev_terr_r, 1'b0, ev_byte, (ev_inv | (ev_brk & in_frame_r)), ev_eof, ev_crc};
	wire [6:0] flag_clr = wr_stat ? {pwdata[6:5], 1'b0, pwdata[3:0]} : 7'h00;
	wire rxf_clr = rd_data | (wr_stat & pwdata[`VSC_ST_RXF]);
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			flags_r <= `VSC_FLAGS_RST;
			fourx_r <= `VSC_CTRL_RST;
		end
		else
		begin
			flags_r[2:0] <= (flags_r[2:0] & ~flag_clr[2:0]) | flag_set[2:0];
			flags_r[3] <= (flags_r[3] & ~rxf_clr) | flag_set[3];
			flags_r[4] <= 1'b0;
			flags_r[6:5] <= (flags_r[6:5] & ~flag_clr[6:5]) | flag_set[6:5];
			// Break inside a frame drops fourfold mode over any write
			if (ev_brk && in_frame_r)
				fourx_r <= 1'b0;
			else if (wr_ctrl)
				fourx_r <= pwdata[`VSC_CT_4X];
		end
	end

	// APB slave: one wait state, registered answer
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end
		else if (psel && penable && !pready)
		begin
			pready <= 1'b1;
			pslverr <= reg_sel(paddr) == SEL_NONE;
			// Unmapped and write accesses read as zero
			if (pwrite || reg_sel(paddr) == SEL_NONE)
				prdata <= 32'h00000000;
			else if (reg_sel(paddr) == SEL_DATA)
				prdata <= {24'h000000, rbyte_r};
			else if (reg_sel(paddr) == SEL_CTRL)
				prdata <= {31'h00000000, fourx_r};
			else
				prdata <= {24'h000000, idle_r, flags_r[6:5], ~tfull_r, flags_r[3:0]};
		end
		else
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
	end

endmodule // vsc_codec

/* test/vsc_bus_node.sv */
// Behavioural far-side node on the wired bus, and a log of the codec's drive.
// Assumes a wired-OR bus: active wins, passive is the pulled rest level.
`timescale 1ns/100ps
module vsc_bus_node #(
	parameter [15:0] SOF_CYC = 16'h1388,
	parameter [15:0] IDLE_CYC = 16'h1d4c
) (
	// Clock
	pclk,
	// Bus
	link_tx,
	link_rx
);
	input wire pclk;
	input wire link_tx;
	output wire link_rx;
	logic node_act = 1'b0; // Own drive, passive at rest
	logic last_r = 1'b0; // Last seen codec level
	int run = 0; // Cycles at that level
	int quiet = 0; // Cycles of passive bus
	int dq[$]; // Logged run lengths
	assign link_rx = link_tx | node_act; // Active dominates
	// Sampled mid-cycle, away from the codec's edge
	always @(negedge pclk)
	begin
		quiet = link_rx ? 0 : quiet + 1;
		if (link_tx !== last_r)
		begin
			dq.push_back(run);
			run = 1;
			last_r = link_tx;
		end
		else
			run = run + 1;
	end
	task pulse(input logic lvl, input int n);
		node_act <= lvl;
		repeat (n) @(posedge pclk);
	endtask
	task wait_idle;
		while (quiet < IDLE_CYC) @(posedge pclk);
	endtask
	// One byte, no check byte: a deliberately broken frame
	task send(input logic [7:0] b);
		wait_idle();
		pulse(1'b1, SOF_CYC);
		for (int i = 7; i >= 0; i--)
			pulse(!i[0], (b[i] ^ !i[0]) ? 3200 : 1600);
		node_act <= 1'b0;
	endtask
endmodule // vsc_bus_node

/* test/vsc_codec_properties.sv */
// Concurrent checks on the codec's APB and link pins.
// Assumes one clock, pclk, and the asynchronous active-low presetn.
`timescale 1ns/100ps
module vsc_codec_properties #(
	parameter [15:0] SOF_CYC = 16'h1388,
	parameter [15:0] BRK_CYC = 16'h1770,
	parameter [15:0] EOF_CYC = 16'h1b58,
	parameter [15:0] IDLE_CYC = 16'h1d4c,
	parameter [15:0] WIN_C_CYC = 16'h1004
) (
	// Clock and reset
	input wire pclk,
	input wire presetn,
	// APB
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	// Link pins
	input wire link_rx,
	input wire link_tx
);
	localparam [15:0] SH = 16'h0640; // Short bit time
	localparam [15:0] LG = 16'h0c80; // Long bit time
	logic [15:0] hi_r; // Cycles driven active
	logic [15:0] lo_r; // Cycles driven passive
	logic [15:0] rq_r; // Cycles the bus has been passive
	wire rd_stat = pready && !pwrite && paddr == 8'h08; // Status read completing
	// Run counters; passive ones saturate so a long idle cannot wrap
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			hi_r <= 16'h0;
			lo_r <= 16'h0;
			rq_r <= 16'h0;
		end
		else
		begin
			hi_r <= link_tx ? hi_r + 16'h1 : 16'h0;
			lo_r <= link_tx ? 16'h0 : lo_r + {15'h0, lo_r != 16'hffff};
			rq_r <= link_rx ? 16'h0 : rq_r + {15'h0, rq_r != 16'hffff};
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_hi_run; $fell(link_tx) |-> hi_r == SH || hi_r == LG || hi_r == SOF_CYC; endproperty
	a_hi_run: assert property (p_hi_run) else $error("bad active run");
	property p_lo_run; $rose(link_tx) |-> lo_r == SH || lo_r == LG || lo_r >= EOF_CYC; endproperty
	a_lo_run: assert property (p_lo_run) else $error("bad passive run");
	property p_no_brk; hi_r <= SOF_CYC; endproperty
	a_no_brk: assert property (p_no_brk) else $error("active too long");
	property p_idle_set; rd_stat && prdata[7] |-> $past(rq_r, 5) >= IDLE_CYC - 16'h8; endproperty
	a_idle_set: assert property (p_idle_set) else $error("idle too early");
	property p_idle_clr; rd_stat && !prdata[7] |-> rq_r < IDLE_CYC + 16'h10; endproperty
	a_idle_clr: assert property (p_idle_clr) else $error("idle missed");
	property p_one_wait; psel && $rose(penable) |=> pready; endproperty
	a_one_wait: assert property (p_one_wait) else $error("late ready");
	property p_pulse; pready |=> !pready; endproperty
	a_pulse: assert property (p_pulse) else $error("ready held");
	property p_unmap; pready && !(paddr inside {8'h00, 8'h04, 8'h08}) |-> pslverr && prdata == 32'h0; endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped not refused");
	property p_wr_zero; pready && pwrite |-> prdata == 32'h0; endproperty
	a_wr_zero: assert property (p_wr_zero) else $error("write data out");
	// Main scenarios reached
	c_tx: cover property ($rose(link_tx) && lo_r >= IDLE_CYC);
	c_err: cover property (pready && pslverr);
	c_idle: cover property (rd_stat && prdata[7]);
endmodule // vsc_codec_properties

bind vsc_codec vsc_codec_properties #(.SOF_CYC(SOF_CYC), .BRK_CYC(BRK_CYC), .EOF_CYC(EOF_CYC),
	.IDLE_CYC(IDLE_CYC), .WIN_C_CYC(WIN_C_CYC)) u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .link_rx(link_rx), .link_tx(link_tx));

/* test/vsc_codec_test.sv */
// Self-checking bench: APB master, bus node, frame and register scenarios.
// Assumes the codec's start, break, end, idle and window-c counts are scaled down by its parameters; bit times stay full length.
`timescale 1ns/100ps
module vsc_codec_test;
	localparam [15:0] SOF = 16'h0e10;
	localparam [15:0] BRK = 16'h0fa0;
	localparam [15:0] EOFC = 16'h1068;
	localparam [15:0] IDLE = 16'h1194;
	localparam [15:0] WINC = 16'h0d48;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	wire [31:0] prdata;
	wire pready;
	wire pslverr;
	wire link_rx;
	wire link_tx;
	int n_errors = 0;
	int tests_run = 0;
	int cyc = 0;
	logic [31:0] seed = 32'ha58950dc;
	logic [31:0] rd; // Read data taken
	logic er; // Error taken
	logic [15:0] w; // Data then check byte
	logic [31:0] rv; // Random control word
	always #20 pclk = ~pclk;
	vsc_codec #(.SOF_CYC(SOF), .BRK_CYC(BRK), .EOF_CYC(EOFC), .IDLE_CYC(IDLE), .WIN_C_CYC(WINC)) dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link_rx(link_rx),
		.link_tx(link_tx));
	vsc_bus_node #(.SOF_CYC(SOF), .IDLE_CYC(IDLE)) node (.pclk(pclk), .link_tx(link_tx), .link_rx(link_rx));
	// Hang guard
	always @(posedge pclk)
	begin
		cyc <= cyc + 1;
		// Ceiling sits above the longest expected run of all scenarios
		if (cyc == 98000)
		begin
			n_errors++;
			finish_test();
		end
	end
	task check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("CHECK FAILED %0t seen %h want %h", $time, seen, exp);
		end
	endtask
	task finish_test;
		$display("checks %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// Setup, access until ready, release, one idle edge
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Ready, read data and error are all taken at the completing rising edge
		do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
		if (n == 20)
			n_errors++;
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	// Remainder after one byte, MSB first
	function logic [7:0] crc(input logic [7:0] r, input logic [7:0] b);
		for (int i = 7; i >= 0; i--)
			r = {r[6:0], 1'b0} ^ ((r[7] ^ b[i]) ? 8'h1d : 8'h00);
		return r;
	endfunction
	// Expected run of bit p: even places passive
	function logic [15:0] dur(input int p, input logic bv);
		return (bv ^ p[0]) ? 16'h0c80 : 16'h0640;
	endfunction
	initial
	begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, 8'h04, 32'h0);
		check(rd, 32'h0);
		apb(1'b0, 8'h08, 32'h0);
		check(rd, 32'h10);
		apb(1'b0, 8'h0c + (8'($random(seed)) & 8'h0c), 32'h0);
		check({er, rd}, {1'b1, 32'h0});
		// Only the enable bit of control sticks
		repeat (3)
		begin
			rv = $random(seed);
			apb(1'b1, 8'h04, rv);
			apb(1'b0, 8'h04, 32'h0);
			check(rd, {31'h0, rv[0]});
		end
		apb(1'b1, 8'h04, 32'h0);
		$display("test registers done");
		// Frame of one byte, watched on the pin
		node.dq.delete();
		w = {8'h55, ~crc(8'hff, 8'h55)};
		apb(1'b1, 8'h00, 32'h155);
		while (node.dq.size() < 18) @(posedge pclk);
		check(32'(node.dq[1]), {16'h0, SOF});
		for (int p = 0; p < 16; p++)
			check(32'(node.dq[p + 2]), {16'h0, dur(p, w[15 - p])});
		repeat (EOFC + 16'h0064) @(posedge pclk);
		apb(1'b0, 8'h08, 32'h0);
		check(rd & 32'h17, 32'h12);
		apb(1'b1, 8'h08, 32'h6f);
		apb(1'b0, 8'h08, 32'h0);
		check(rd & 32'h6f, 32'h0);
		$display("test transmit done");
		// Frame missing its check byte
		node.send(8'h55);
		repeat (WINC + 16'h00c8) @(posedge pclk);
		apb(1'b0, 8'h08, 32'h0);
		check(rd & 32'h0e, 32'h08);
		apb(1'b0, 8'h00, 32'h0);
		check(rd & 32'hff, 32'h55);
		repeat (16'h0258) @(posedge pclk);
		apb(1'b0, 8'h08, 32'h0);
		check(rd & 32'h03, {30'h0, 1'b1, crc(8'hff, 8'h55) != 8'hc4});
		apb(1'b1, 8'h08, 32'h6f);
		$display("test receive done");
		// Break inside a fourfold frame
		apb(1'b1, 8'h04, 32'h1);
		node.wait_idle();
		node.pulse(1'b1, SOF >> 2);
		node.pulse(1'b0, 16'h0640 >> 2);
		node.pulse(1'b1, BRK + 16'h0190);
		node.pulse(1'b0, 16);
		apb(1'b0, 8'h08, 32'h0);
		check(rd & 32'h04, 32'h04);
		apb(1'b0, 8'h04, 32'h0);
		check(rd, 32'h0);
		apb(1'b1, 8'h08, 32'h6f);
		$display("test break done");
		// Idle, then a rival holding the bus
		node.wait_idle();
		repeat (16) @(posedge pclk);
		apb(1'b0, 8'h08, 32'h0);
		check({31'h0, rd[7]}, 32'h1);
		// Send at top priority while a rival holds the bus active
		apb(1'b1, 8'h00, 32'h100);
		while (link_tx !== 1'b1) @(posedge pclk);
		node.pulse(1'b1, BRK + 16'h0190);
		@(negedge pclk);
		check({31'h0, link_tx}, 32'h0);
		node.pulse(1'b0, 16);
		apb(1'b0, 8'h08, 32'h0);
		check({31'h0, |rd[6:5]}, 32'h1);
		$display("test contention done");
		finish_test();
	end
endmodule // vsc_codec_test
